// ---- directional_overpower_protection_tb.sv ----
// Self-checking bench for the over-power block
`timescale 1ns/1ps
`default_nettype none
module directional_overpower_protection_tb;
  import dop_pkg::*;
  localparam int CYC = 4;
  logic clk, rst, psel, pen, pwr, pready, pslverr, blk, vtb, st, tr, irq, mv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic signed [PH_W-1:0] ure, uim, ire, mu_re, mu_im, mi_re, mi_im;
  int n_fail = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  dop_meas_model u_meas (.clk_i(clk), .rst_i(rst), .u_re_i(ure), .u_im_i(uim), .i_re_i(ire),
    .valid_o(mv), .u_re_o(mu_re), .u_im_o(mu_im), .i_re_o(mi_re), .i_im_o(mi_im));
  dop_overpower #(.CYC_PER_MS_P(CYC)) DUT (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MEAS_VALID_I(mv),
    .U_RE_L1_I(mu_re), .U_IM_L1_I(mu_im), .U_RE_L2_I(mu_re), .U_IM_L2_I(mu_im),
    .U_RE_L3_I(mu_re), .U_IM_L3_I(mu_im), .I_RE_L1_I(mi_re), .I_IM_L1_I(mi_im),
    .I_RE_L2_I(mi_re), .I_IM_L2_I(mi_im), .I_RE_L3_I(mi_re), .I_IM_L3_I(mi_im),
    .GENERAL_BLOCK_I(blk), .VT_SUPERVISION_BLOCK_I(vtb), .GENERAL_START_FLAG_O(st),
    .GENERAL_TRIP_FLAG_O(tr), .IRQ_O(irq));
  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w)
      chk({31'h0, pslverr}, {31'h0, a > ADDR_Q_PWR});
    if (!w)
      chk(prdata, d);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, a, d);
    apb(1'b0, a, e);
  endtask : wrd
  task automatic meas(input int u, input int ui, input int i);
    @(posedge clk);
    ure <= PH_W'(u);
    uim <= PH_W'(ui);
    ire <= PH_W'(i);
  endtask : meas
  task automatic wait_st(input logic e);
    int n;
    n = 0;
    while (st !== e && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, st}, {31'h0, e});
  endtask : wait_st
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial
  begin
    int n;
    clk = 0; rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
    ure = 0; uim = 0; ire = 0; blk = 0; vtb = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_ANGLE, 32'h0);
    apb(1'b0, ADDR_SPOWER, 32'h64);
    apb(1'b0, ADDR_DELAY, 32'hc8);
    apb(1'b0, 8'h40, 32'h0);
    wrd(ADDR_ANGLE, -32'sd200, 32'h14d);
    wrd(ADDR_ANGLE, 32'd181, 32'hb4);
    wrd(ADDR_SPOWER, 32'd5, 32'ha);
    wrd(ADDR_SPOWER, 32'd3000, 32'h7d0);
    wrd(ADDR_DELAY, 32'd70000, 32'hea60);
    wrd(ADDR_DELAY, 32'd100, 32'hc8);
    wrd(ADDR_ANGLE, 32'd0, 32'h0);
    meas(700, 0, 1);
    repeat (60) @(negedge clk);
    chk({30'h0, tr, st}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    wait_st(1'b1);
    n = 0;
    do begin @(negedge clk); n++; end while (tr !== 1'b1 && n < 2000);
    chk(n, DELAY_MIN * CYC);
    apb(1'b0, ADDR_STATE, 32'h7);
    apb(1'b0, ADDR_P_PWR, 32'h106);
    apb(1'b0, ADDR_Q_PWR, 32'h0);
    meas(650, 0, 1);
    repeat (60) @(negedge clk);
    chk({31'h0, st}, 32'h1);
    meas(600, 0, 1);
    wait_st(1'b0);
    repeat (2) @(negedge clk);
    chk({31'h0, tr}, 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'hf);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'hf);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h3);
    meas(700, 0, 1);
    wait_st(1'b1);
    repeat (900) @(negedge clk);
    chk({31'h0, tr}, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      blk <= (i == 0);
      vtb <= (i == 1);
      wait_st(1'b0);
      repeat (6) @(posedge clk);
      blk <= 1'b0;
      vtb <= 1'b0;
      wait_st(1'b1);
    end
    apb(1'b1, ADDR_ANGLE, 32'd180);
    wait_st(1'b0);
    meas(700, 0, -1);
    wait_st(1'b1);
    meas(0, 700, 1);
    apb(1'b1, ADDR_ANGLE, -32'sd90);
    wait_st(1'b0);
    apb(1'b1, ADDR_ANGLE, 32'd90);
    wait_st(1'b1);
    apb(1'b0, ADDR_Q_PWR, 32'h106);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_st(1'b0);
    end_sim();
  end
endmodule : directional_overpower_protection_tb
`default_nettype wire

// ---- dop_cordic.sv ----
// Sequential rotator: projects a power point onto the direction of a set angle
`timescale 1ns/1ps
`default_nettype none
module dop_cordic
  import dop_pkg::*;
(
  // Clock and reset
  input  wire logic                         SYS_CLK_I,
  input  wire logic                         RESET_I,
  // Request
  input  wire logic                         start_i,
  input  wire logic signed [PWR_W-1:0]      x_i,
  input  wire logic signed [PWR_W-1:0]      y_i,
  input  wire logic signed [ANG_W-1:0]      ang_i,
  // Answer
  output logic                              done_o,
  output logic signed [CRD_W-1:0]           proj_o
);

  typedef enum logic { CRD_IDLE, CRD_RUN } dop_crd_state_t;

  dop_crd_state_t          state, next_state;
  logic signed [CRD_W-1:0] x, y, next_x, next_y, next_proj;
  logic signed [Z_W-1:0]   z, next_z, z0;
  logic [3:0]              it, next_it;
  logic                    next_done;

  // Arctangent of 2^-i in 1/256 degree
  function automatic logic signed [Z_W-1:0] atan_tab(input logic [3:0] i);
    case (i)
      4'h0:    return 18'sh02d00;
      4'h1:    return 18'sh01a91;
      4'h2:    return 18'sh00e09;
      4'h3:    return 18'sh00720;
      4'h4:    return 18'sh00394;
      4'h5:    return 18'sh001ca;
      4'h6:    return 18'sh000e5;
      4'h7:    return 18'sh00073;
      4'h8:    return 18'sh00039;
      4'h9:    return 18'sh0001d;
      4'ha:    return 18'sh0000e;
      4'hb:    return 18'sh00007;
      4'hc:    return 18'sh00004;
      default: return 18'sh00002;
    endcase
  endfunction : atan_tab

  always_comb
  begin
    z0         = -$signed({{(Z_W-ANG_W-ANG_FRAC){ang_i[ANG_W-1]}}, ang_i, 8'h00});
    next_state = state;
    next_x     = x;
    next_y     = y;
    next_z     = z;
    next_it    = it;
    next_done  = 1'b0;
    next_proj  = proj_o;
    case (state)
      CRD_IDLE:
      begin
        if (start_i)
        begin
          // Fold the angle into +-90 degrees first
          if (z0 > Z_W'(RIGHT_ANGLE))
          begin
            next_x = -CRD_W'(y_i);
            next_y = CRD_W'(x_i);
            next_z = z0 - Z_W'(RIGHT_ANGLE);
          end
          else if (z0 < -Z_W'(RIGHT_ANGLE))
          begin
            next_x = CRD_W'(y_i);
            next_y = -CRD_W'(x_i);
            next_z = z0 + Z_W'(RIGHT_ANGLE);
          end
          else
          begin
            next_x = CRD_W'(x_i);
            next_y = CRD_W'(y_i);
            next_z = z0;
          end
          next_it    = 4'h0;
          next_state = CRD_RUN;
        end
      end
      default:
      begin
        if (z >= 0)
        begin
          next_x = x - (y >>> it);
          next_y = y + (x >>> it);
          next_z = z - atan_tab(it);
        end
        else
        begin
          next_x = x + (y >>> it);
          next_y = y - (x >>> it);
          next_z = z + atan_tab(it);
        end
        next_it = it + 4'h1;
        if (it == 4'(CORDIC_ITER - 1))
        begin
          next_state = CRD_IDLE;
          next_done  = 1'b1;
          next_proj  = next_x;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      state  <= CRD_IDLE;
      x      <= '0;
      y      <= '0;
      z      <= '0;
      it     <= 4'h0;
      done_o <= 1'b0;
      proj_o <= '0;
    end
    else
    begin
      state  <= next_state;
      x      <= next_x;
      y      <= next_y;
      z      <= next_z;
      it     <= next_it;
      done_o <= next_done;
      proj_o <= next_proj;
    end
  end

endmodule : dop_cordic
`default_nettype wire

// ---- dop_meas_model.sv ----
// Measurement front end model sending periodic phasor frames
`timescale 1ns/1ps
`default_nettype none
module dop_meas_model
  import dop_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Wanted phasors, same on every phase
  input  wire logic signed [PH_W-1:0] u_re_i,
  input  wire logic signed [PH_W-1:0] u_im_i,
  input  wire logic signed [PH_W-1:0] i_re_i,
  // Frame to the block
  output logic                        valid_o,
  output logic signed [PH_W-1:0]      u_re_o,
  output logic signed [PH_W-1:0]      u_im_o,
  output logic signed [PH_W-1:0]      i_re_o,
  output logic signed [PH_W-1:0]      i_im_o
);
  logic [4:0] cnt, next_cnt;
  // Frames 20 cycles apart, above the minimum spacing of 15
  always_comb
  begin
    next_cnt = (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 5'h00;
    else
      cnt <= next_cnt;
  end
  // Data lines carry inverted or toggling junk outside the valid cycle
  assign valid_o = !rst_i && cnt == 5'h13;
  assign u_re_o = valid_o ? u_re_i : ~u_re_i;
  assign u_im_o = valid_o ? u_im_i : ~u_im_i;
  assign i_re_o = valid_o ? i_re_i : ~i_re_i;
  assign i_im_o = valid_o ? 16'h0000 : {PH_W{cnt[0]}};
endmodule : dop_meas_model
`default_nettype wire

// ---- dop_overpower.sv ----
// Directional over-power decision, definite-time trip and APB register file
//
// What this block does
// - Compute three-phase P and Q from phasors
// - Characteristic line through setpoint, perpendicular to it
// - Start decision when point beyond line
// - Lower threshold by hysteresis while the direction decision is set
// - Start needs direction, no block, no VT block
// - Start runs delay timer; expiry trips
// - Start-only setting suppresses trip, default false
// - Direction angle -179..180 degrees, default 0
// - Start power 1.0..200.0 percent, default 10.0
// - Trip delay 200..60000 ms, default 200
// - Exactly two flags: general start, general trip
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dop_overpower
  import dop_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  // Clock and reset
  input  wire logic                      SYS_CLK_I,
  input  wire logic                      RESET_I,
  // APB slave
  input  wire logic                      PSEL_I,
  input  wire logic                      PENABLE_I,
  input  wire logic                      PWRITE_I,
  input  wire logic [7:0]                PADDR_I,
  input  wire logic [31:0]               PWDATA_I,
  output logic [31:0]                    PRDATA_O,
  output logic                           PREADY_O,
  output logic                           PSLVERR_O,
  // Measurement front end, fundamental phasors
  input  wire logic                      MEAS_VALID_I,
  input  wire logic signed [PH_W-1:0]    U_RE_L1_I,
  input  wire logic signed [PH_W-1:0]    U_IM_L1_I,
  input  wire logic signed [PH_W-1:0]    U_RE_L2_I,
  input  wire logic signed [PH_W-1:0]    U_IM_L2_I,
  input  wire logic signed [PH_W-1:0]    U_RE_L3_I,
  input  wire logic signed [PH_W-1:0]    U_IM_L3_I,
  input  wire logic signed [PH_W-1:0]    I_RE_L1_I,
  input  wire logic signed [PH_W-1:0]    I_IM_L1_I,
  input  wire logic signed [PH_W-1:0]    I_RE_L2_I,
  input  wire logic signed [PH_W-1:0]    I_IM_L2_I,
  input  wire logic signed [PH_W-1:0]    I_RE_L3_I,
  input  wire logic signed [PH_W-1:0]    I_IM_L3_I,
  // Block inputs from pins
  input  wire logic                      GENERAL_BLOCK_I,
  input  wire logic                      VT_SUPERVISION_BLOCK_I,
  // Protection flags and interrupt
  output logic                           GENERAL_START_FLAG_O,
  output logic                           GENERAL_TRIP_FLAG_O,
  output logic                           IRQ_O
);

  // Settings
  logic                    operation, start_only;
  logic signed [ANG_W-1:0] angle;
  logic [SPW_W-1:0]        start_power;
  logic [DLY_W-1:0]        delay_ms;
  logic [NOM_W-1:0]        pwr_per_tenth;
  logic [EV_W-1:0]         irq_stat, irq_mask;
  logic                    next_operation, next_start_only;
  logic signed [ANG_W-1:0] next_angle;
  logic [SPW_W-1:0]        next_start_power;
  logic [DLY_W-1:0]        next_delay_ms;
  logic [EV_W-1:0]         next_irq_stat, next_irq_mask;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;
  logic                    wr_en, rd_setup;
  logic                    blk_s1, blk_s2, vts_s1, vts_s2;

  // Power and decision
  logic signed [PWR_W-1:0] p_pwr, q_pwr, next_p_pwr, next_q_pwr;
  logic                    calc_go, next_calc_go;
  logic                    crd_done;
  logic signed [CRD_W-1:0] proj;
  logic [THR_W-1:0]        thr_base, thr_eff;
  logic                    dir_ok, next_dir_ok;
  logic                    gen_start, next_gen_start;
  logic                    gen_trip, next_gen_trip;
  logic [31:0]             pre_cnt, next_pre_cnt;
  logic [DLY_W-1:0]        ms_cnt, next_ms_cnt;
  logic [EV_W-1:0]         events;

  // Pin inputs pass two flip-flops
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
      vts_s1 <= 1'b0;
      vts_s2 <= 1'b0;
    end
    else
    begin
      blk_s1 <= GENERAL_BLOCK_I;
      blk_s2 <= blk_s1;
      vts_s1 <= VT_SUPERVISION_BLOCK_I;
      vts_s2 <= vts_s1;
    end
  end

  // Three-phase active and reactive power
  always_comb
  begin
    next_p_pwr   = p_pwr;
    next_q_pwr   = q_pwr;
    next_calc_go = 1'b0;
    if (MEAS_VALID_I)
    begin
      next_p_pwr   = U_RE_L1_I * I_RE_L1_I + U_IM_L1_I * I_IM_L1_I
                   + U_RE_L2_I * I_RE_L2_I + U_IM_L2_I * I_IM_L2_I
                   + U_RE_L3_I * I_RE_L3_I + U_IM_L3_I * I_IM_L3_I;
      next_q_pwr   = U_IM_L1_I * I_RE_L1_I - U_RE_L1_I * I_IM_L1_I
                   + U_IM_L2_I * I_RE_L2_I - U_RE_L2_I * I_IM_L2_I
                   + U_IM_L3_I * I_RE_L3_I - U_RE_L3_I * I_IM_L3_I;
      next_calc_go = 1'b1;
    end
  end

  // Projection of the power point onto the setpoint direction
  dop_cordic u_cordic (
    .SYS_CLK_I (SYS_CLK_I),
    .RESET_I   (RESET_I),
    .start_i   (calc_go),
    .x_i       (p_pwr),
    .y_i       (q_pwr),
    .ang_i     (angle),
    .done_o    (crd_done),
    .proj_o    (proj)
  );

  // Setpoint magnitude, scaled by the rotator gain
  always_comb
  begin
    thr_base = THR_W'((THR_W'(start_power) * THR_W'(pwr_per_tenth)
                       * THR_W'(CORDIC_GAIN_Q12)) >> 12);
    if (dir_ok)
      thr_eff = THR_W'((thr_base * THR_W'(HYST_Q8)) >> 8);
    else
      thr_eff = thr_base;
  end

  // Direction decision, start and definite-time trip
  always_comb
  begin
    next_dir_ok = dir_ok;
    if (!operation)
      next_dir_ok = 1'b0;
    else if (crd_done)
      next_dir_ok = ($signed({{(THR_W-CRD_W){proj[CRD_W-1]}}, proj})
                     > $signed(thr_eff));
    next_gen_start = operation & dir_ok & ~blk_s2 & ~vts_s2;
    next_pre_cnt   = 32'h0;
    next_ms_cnt    = {DLY_W{1'b0}};
    next_gen_trip  = 1'b0;
    if (gen_start && next_gen_start && !start_only)
    begin
      next_gen_trip = gen_trip;
      if (!gen_trip)
      begin
        next_pre_cnt = pre_cnt + 32'h1;
        next_ms_cnt  = ms_cnt;
        if (pre_cnt == 32'(CYC_PER_MS_P - 1))
        begin
          next_pre_cnt = 32'h0;
          next_ms_cnt  = ms_cnt + {{(DLY_W-1){1'b0}}, 1'b1};
          if (ms_cnt + {{(DLY_W-1){1'b0}}, 1'b1} >= delay_ms)
            next_gen_trip = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      p_pwr     <= '0;
      q_pwr     <= '0;
      calc_go   <= 1'b0;
      dir_ok    <= 1'b0;
      gen_start <= 1'b0;
      gen_trip  <= 1'b0;
      pre_cnt   <= 32'h0;
      ms_cnt    <= {DLY_W{1'b0}};
    end
    else
    begin
      p_pwr     <= next_p_pwr;
      q_pwr     <= next_q_pwr;
      calc_go   <= next_calc_go;
      dir_ok    <= next_dir_ok;
      gen_start <= next_gen_start;
      gen_trip  <= next_gen_trip;
      pre_cnt   <= next_pre_cnt;
      ms_cnt    <= next_ms_cnt;
    end
  end

  // The only two protection flags
  assign GENERAL_START_FLAG_O = gen_start;
  assign GENERAL_TRIP_FLAG_O  = gen_trip;

  // Flag edges as interrupt events
  always_comb
  begin
    events               = {EV_W{1'b0}};
    events[EV_START_ON]  = next_gen_start & ~gen_start;
    events[EV_START_OFF] = ~next_gen_start & gen_start;
    events[EV_TRIP_ON]   = next_gen_trip & ~gen_trip;
    events[EV_TRIP_OFF]  = ~next_gen_trip & gen_trip;
  end

  // APB register file, zero wait states
  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I;
  assign PREADY_O = 1'b1;
  assign IRQ_O    = |(irq_stat & irq_mask);

  always_comb
  begin
    next_operation   = operation;
    next_start_only  = start_only;
    next_angle       = angle;
    next_start_power = start_power;
    next_delay_ms    = delay_ms;
    next_irq_mask    = irq_mask;
    next_irq_stat    = irq_stat;
    next_prdata      = PRDATA_O;
    next_pslverr     = PSLVERR_O;
    if (wr_en)
    begin
      if (PADDR_I == ADDR_CTRL)
      begin
        next_operation  = PWDATA_I[CTRL_OPER_BIT];
        next_start_only = PWDATA_I[CTRL_STONLY_BIT];
      end
      else if (PADDR_I == ADDR_ANGLE)
        next_angle = ANG_W'(clamp_setting($signed(PWDATA_I), ANGLE_MIN, ANGLE_MAX));
      else if (PADDR_I == ADDR_SPOWER)
        next_start_power = SPW_W'(clamp_setting($signed(PWDATA_I), SPOWER_MIN,
                                                SPOWER_MAX));
      else if (PADDR_I == ADDR_DELAY)
        next_delay_ms = DLY_W'(clamp_setting($signed(PWDATA_I), DELAY_MIN,
                                             DELAY_MAX));
      else if (PADDR_I == ADDR_IRQ_STAT)
        next_irq_stat = irq_stat & ~PWDATA_I[EV_W-1:0];
      else if (PADDR_I == ADDR_IRQ_MASK)
        next_irq_mask = PWDATA_I[EV_W-1:0];
    end
    // Set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
    if (rd_setup)
    begin
      next_prdata  = 32'h0;
      next_pslverr = 1'b0;
      if (PADDR_I == ADDR_CTRL)
      begin
        next_prdata[CTRL_OPER_BIT]   = operation;
        next_prdata[CTRL_STONLY_BIT] = start_only;
      end
      else if (PADDR_I == ADDR_ANGLE)
        next_prdata[ANG_W-1:0] = angle;
      else if (PADDR_I == ADDR_SPOWER)
        next_prdata[SPW_W-1:0] = start_power;
      else if (PADDR_I == ADDR_DELAY)
        next_prdata[DLY_W-1:0] = delay_ms;
      else if (PADDR_I == ADDR_STATE)
      begin
        next_prdata[ST_START_BIT] = gen_start;
        next_prdata[ST_TRIP_BIT]  = gen_trip;
        next_prdata[ST_DIR_BIT]   = dir_ok;
        next_prdata[ST_BLK_BIT]   = blk_s2;
        next_prdata[ST_VTS_BIT]   = vts_s2;
      end
      else if (PADDR_I == ADDR_IRQ_STAT)
        next_prdata[EV_W-1:0] = irq_stat;
      else if (PADDR_I == ADDR_IRQ_MASK)
        next_prdata[EV_W-1:0] = irq_mask;
      else if (PADDR_I == ADDR_P_PWR)
        next_prdata = p_pwr[PWR_W-1:PWR_W-32];
      else if (PADDR_I == ADDR_Q_PWR)
        next_prdata = q_pwr[PWR_W-1:PWR_W-32];
      else
        next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      operation     <= 1'b0;
      start_only    <= 1'b0;
      angle         <= ANGLE_RST;
      start_power   <= SPOWER_RST;
      delay_ms      <= DELAY_RST;
      pwr_per_tenth <= PWR_PER_TENTH_RST;
      irq_stat      <= {EV_W{1'b0}};
      irq_mask      <= {EV_W{1'b0}};
      PRDATA_O      <= 32'h0;
      PSLVERR_O     <= 1'b0;
    end
    else
    begin
      operation     <= next_operation;
      start_only    <= next_start_only;
      angle         <= next_angle;
      start_power   <= next_start_power;
      delay_ms      <= next_delay_ms;
      pwr_per_tenth <= pwr_per_tenth;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      PRDATA_O      <= next_prdata;
      PSLVERR_O     <= next_pslverr;
    end
  end

endmodule : dop_overpower
`default_nettype wire

// ---- dop_overpower_checker.sv ----
// Port assertions for the over-power block
`timescale 1ns/1ps
`default_nettype none
module dop_overpower_checker
  import dop_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
)
(
  // Clock, reset and register bus
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  // Pins and flags
  input wire logic        GENERAL_BLOCK_I,
  input wire logic        VT_SUPERVISION_BLOCK_I,
  input wire logic        GENERAL_START_FLAG_O,
  input wire logic        GENERAL_TRIP_FLAG_O
);
  logic        oper, next_oper, stonly, next_stonly, wr;
  logic [31:0] dly, next_dly, cnt, next_cnt;
  // Shadow of control and delay settings
  always_comb
  begin
    wr = PSEL_I && PENABLE_I && PWRITE_I;
    next_oper = oper;
    next_stonly = stonly;
    next_dly = dly;
    next_cnt = GENERAL_START_FLAG_O ? cnt + 32'h1 : 32'h0;
    if (wr && PADDR_I == ADDR_CTRL)
    begin
      next_oper = PWDATA_I[CTRL_OPER_BIT];
      next_stonly = PWDATA_I[CTRL_STONLY_BIT];
    end
    if (wr && PADDR_I == ADDR_DELAY)
      next_dly = ($signed(PWDATA_I) < DELAY_MIN) ? 32'(DELAY_MIN)
               : ($signed(PWDATA_I) > DELAY_MAX) ? 32'(DELAY_MAX) : PWDATA_I;
  end
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      oper <= 1'b0;
      stonly <= 1'b0;
      dly <= 32'(DELAY_RST);
      cnt <= 32'h0;
    end
    else
    begin
      oper <= next_oper;
      stonly <= next_stonly;
      dly <= next_dly;
      cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_blocked; GENERAL_BLOCK_I [*5]; endsequence
  sequence s_vt_blocked; VT_SUPERVISION_BLOCK_I [*5]; endsequence
  a_block_gate: assert property (s_blocked |-> !GENERAL_START_FLAG_O)
    else $error("start while blocked");
  a_vts_gate: assert property (s_vt_blocked |-> !GENERAL_START_FLAG_O)
    else $error("start while vt blocked");
  a_start_oper: assert property ($rose(GENERAL_START_FLAG_O) |-> oper)
    else $error("start rose while off");
  property p_off_quiet;
    !oper [*3] |-> !GENERAL_START_FLAG_O && !GENERAL_TRIP_FLAG_O;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("flag while off");
  a_stonly_notrip: assert property (stonly [*3] |-> !GENERAL_TRIP_FLAG_O)
    else $error("trip in start only");
  a_trip_start: assert property (GENERAL_TRIP_FLAG_O |-> $past(GENERAL_START_FLAG_O))
    else $error("trip without start");
  a_trip_release: assert property ($fell(GENERAL_START_FLAG_O) |=> !GENERAL_TRIP_FLAG_O)
    else $error("trip held after start");
  property p_trip_delay;
    $rose(GENERAL_TRIP_FLAG_O) |-> cnt == dly * CYC_PER_MS_P;
  endproperty
  a_trip_delay: assert property (p_trip_delay)
    else $error("trip delay wrong");
endmodule : dop_overpower_checker
bind dop_overpower dop_overpower_checker #(.CYC_PER_MS_P(CYC_PER_MS_P)) u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .GENERAL_BLOCK_I(GENERAL_BLOCK_I), .VT_SUPERVISION_BLOCK_I(VT_SUPERVISION_BLOCK_I),
  .GENERAL_START_FLAG_O(GENERAL_START_FLAG_O), .GENERAL_TRIP_FLAG_O(GENERAL_TRIP_FLAG_O));
`default_nettype wire

// ---- dop_pkg.sv ----
// Constants, register map and helpers for the directional over-power block
package dop_pkg;

  // Data widths
  localparam int PH_W    = 16;
  localparam int PWR_W   = 35;
  localparam int CRD_W   = PWR_W + 2;
  localparam int ANG_W   = 9;
  localparam int SPW_W   = 11;
  localparam int DLY_W   = 16;
  localparam int NOM_W   = 16;
  localparam int THR_W   = 48;
  localparam int Z_W     = 18;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_ANGLE    = 8'h04;
  localparam logic [7:0] ADDR_SPOWER   = 8'h08;
  localparam logic [7:0] ADDR_DELAY    = 8'h0c;
  localparam logic [7:0] ADDR_STATE    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_P_PWR    = 8'h1c;
  localparam logic [7:0] ADDR_Q_PWR    = 8'h20;

  // Field positions
  localparam int CTRL_OPER_BIT   = 0;
  localparam int CTRL_STONLY_BIT = 1;
  localparam int ST_START_BIT    = 0;
  localparam int ST_TRIP_BIT     = 1;
  localparam int ST_DIR_BIT      = 2;
  localparam int ST_BLK_BIT      = 3;
  localparam int ST_VTS_BIT      = 4;
  localparam int EV_W            = 4;
  localparam int EV_START_ON     = 0;
  localparam int EV_START_OFF    = 1;
  localparam int EV_TRIP_ON      = 2;
  localparam int EV_TRIP_OFF     = 3;

  // Setting limits and reset values
  localparam int ANGLE_MIN  = -179;
  localparam int ANGLE_MAX  = 180;
  localparam logic signed [ANG_W-1:0] ANGLE_RST = 9'sh000;
  localparam int SPOWER_MIN = 10;
  localparam int SPOWER_MAX = 2000;
  localparam logic [SPW_W-1:0] SPOWER_RST = 11'h064;
  localparam int DELAY_MIN  = 200;
  localparam int DELAY_MAX  = 60000;
  localparam logic [DLY_W-1:0] DELAY_RST = 16'h00c8;
  localparam logic [NOM_W-1:0] PWR_PER_TENTH_RST = 16'h0001;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_IN_PS      = 1000000000;
  localparam int CYC_PER_MS    = MS_IN_PS / CLK_PERIOD_PS;

  // Characteristic arithmetic
  localparam int ANG_FRAC      = 8;
  localparam int CORDIC_ITER   = 14;
  localparam int RIGHT_ANGLE   = 90 * 256;
  localparam logic [12:0] CORDIC_GAIN_Q12 = 13'h1a5a;
  localparam logic [7:0]  HYST_Q8         = 8'hf3;

  // Clamp a written setting into its legal range
  function automatic int clamp_setting(input int v, input int lo, input int hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    else
      return v;
  endfunction : clamp_setting

endpackage : dop_pkg
